// ===== core/psc_pkg.sv
// Purpose: shared constants for the positioning start/completion link
// Assumes: 250 MHz control clock
// Notes: times kept in microseconds, cycle counts derived here
package psc_pkg;
    localparam int CLK_MHZ = 250;
    localparam int START_DELAY_MAX_US = 3000;
    localparam int START_PULSE_MIN_US = 6000;
    // longest time rounds down
    localparam int START_DELAY_CYC = START_DELAY_MAX_US * CLK_MHZ;
    // least time rounds up (integral here)
    localparam int START_PULSE_CYC = START_PULSE_MIN_US * CLK_MHZ;
    localparam int POS_W = 24;
    localparam int TRQ_W = 16;
    localparam logic [POS_W-1:0] IN_POS_RANGE_RST = 24'h00_0064;
    localparam logic [POS_W-1:0] ROUGH_RANGE_RST = 24'h00_0000;
    localparam logic [TRQ_W-1:0] TRQ_LIMIT_RST = 16'h03E8;
    typedef enum logic [2:0] {
        PSC_IDLE = 3'b001,
        PSC_WAIT = 3'b010,
        PSC_RUN = 3'b100
    } psc_dev_state_t;
    typedef enum logic [2:0] {
        PSC_H_IDLE = 3'b001,
        PSC_H_PULSE = 3'b010,
        PSC_H_DONE = 3'b100
    } psc_host_state_t;
endpackage : psc_pkg

// ===== core/psc_link_if.sv
// Purpose: discrete signals between controller and amplifier
// Assumes: single clock, all levels synchronous
// Notes: one modport per party
`timescale 1ns/10ps
`default_nettype none
interface psc_link_if;
    logic forwardStartIn;
    logic reverseStartIn;
    logic temporaryStopRestartIn;
    logic servoOnIn;
    logic forcedStopIn;
    logic readyOut;
    logic movementFinishOut;
    logic roughMatchOut;
    logic inPositionOut;
    modport device (
        input forwardStartIn, reverseStartIn, temporaryStopRestartIn, servoOnIn, forcedStopIn,
        output readyOut, movementFinishOut, roughMatchOut, inPositionOut
    );
    modport ctrl (
        output forwardStartIn, reverseStartIn, temporaryStopRestartIn, servoOnIn, forcedStopIn,
        input readyOut, movementFinishOut, roughMatchOut, inPositionOut
    );
endinterface : psc_link_if
`default_nettype wire

// ===== core/psc_device.sv
// Purpose: amplifier end: start acceptance, completion outputs, torque clamp
// Assumes: position command and feedback come from the motion core as counts
// Notes: alarm and main power arrive as plain levels
// Notes on behaviour
// R1 - starts ignored before main power established
// R2 - controller gates starts with ready output
// R3 - start only on off-to-on edge
// R4 - start processing within 3 ms
// R5 - controller holds start pulses 6 ms
// R6 - no new start while operating
// R7 - next start after finish or rough-match (controller waits on movement finish only)
// R8 - resume servo-on after stop asserts completion outputs
// R9 - controller confirms point table before restart
// R10 - movement finish only with servo on
// R11 - movement finish low while commanding
// R12 - rough match servo on, not during operation
// R13 - in-position from feedback vs range
// R14 - torque clamped to forward/reverse limits
// R15 - edge detect by sample compare, one-cycle request
`timescale 1ns/10ps
`default_nettype none
module psc_device
    import psc_pkg::*;
#(
    parameter int DELAY_CYC = START_DELAY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link to controller
    psc_link_if.device link,
    // amplifier status
    input wire logic mainPowerOkIn,
    input wire logic alarmIn,
    // parameters
    input wire logic [POS_W-1:0] inPositionRangeParam,
    input wire logic [POS_W-1:0] roughMatchRangeParam,
    input wire logic [TRQ_W-1:0] forwardTorqueLimitParam,
    input wire logic [TRQ_W-1:0] reverseTorqueLimitParam,
    // motion core
    input wire logic cmdDoneIn,
    input wire logic [POS_W-1:0] cmdRemainIn,
    input wire logic [POS_W-1:0] droopIn,
    input wire logic signed [TRQ_W:0] torqueReqIn,
    output logic startPulse,
    output logic startReverse,
    output logic operating,
    output logic signed [TRQ_W:0] torqueCmd
);
    psc_dev_state_t state_r;
    logic [31:0] delayCnt_r;
    logic stopped_r;
    logic servoOk;
    logic [1:0] startLvl;
    logic [1:0] startEdge;
    logic fwdEdge, revEdge;
    logic stopCond;
    logic accept;
    logic idleNow;
    logic inRange;
    logic holdDone;
    logic signed [TRQ_W:0] fwdLimit;
    logic signed [TRQ_W:0] revLimit;

    assign servoOk = link.servoOnIn && !link.forcedStopIn && !alarmIn;
    assign stopCond = !servoOk;
    // index 0 forward, index 1 reverse
    assign startLvl = {link.reverseStartIn, link.forwardStartIn};
    assign fwdEdge = startEdge[0];
    assign revEdge = startEdge[1];

    generate
        for (genvar g = 0; g < 2; g++) begin : g_edge
            logic prev_r;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    prev_r <= 1'b0;
                end else begin
                    // sample every cycle so a held level never retriggers
                    prev_r <= startLvl[g]; // [R15]
                end
            end
            assign startEdge[g] = startLvl[g] && !prev_r; // [R3] [R15]
        end
    endgenerate

    // edges before main power, with servo off or while paused are dropped
    assign accept = (fwdEdge || revEdge) && mainPowerOkIn && servoOk
        && !link.temporaryStopRestartIn; // [R1] [R3]

    // accepted start state machine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= PSC_IDLE;
            delayCnt_r <= '0;
            startPulse <= 1'b0;
            startReverse <= 1'b0;
        end else begin
            startPulse <= 1'b0;
            case (state_r)
                PSC_IDLE: begin
                    if (accept) begin // [R1]
                        state_r <= PSC_WAIT;
                        startReverse <= revEdge && !fwdEdge;
                        delayCnt_r <= '0;
                    end
                end
                PSC_WAIT: begin
                    if (stopCond) begin
                        state_r <= PSC_IDLE;
                    end else if (delayCnt_r >= 32'(DELAY_CYC - 1) || delayCnt_r >= 32'h0000_0001) begin // [R4]
                        startPulse <= 1'b1;
                        state_r <= PSC_RUN;
                    end else begin
                        delayCnt_r <= delayCnt_r + 32'h0000_0001;
                    end
                end
                PSC_RUN: begin
                    // new edges are ignored here
                    if (stopCond || cmdDoneIn) begin // [R6]
                        state_r <= PSC_IDLE;
                    end
                end
                default: state_r <= PSC_IDLE;
            endcase
        end
    end

    // abort memory: set wins over the clear by a new start
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stopped_r <= 1'b0;
        end else if (stopCond && state_r != PSC_IDLE) begin // [R8]
            stopped_r <= 1'b1;
        end else if (state_r == PSC_WAIT) begin
            stopped_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            operating <= 1'b0;
        end else begin
            operating <= (state_r != PSC_IDLE) && !stopCond && !cmdDoneIn;
        end
    end

    assign idleNow = (state_r == PSC_IDLE);
    assign inRange = (droopIn <= inPositionRangeParam);
    // after an aborted move the outputs report done once servo is on again, until the next start
    assign holdDone = stopped_r && idleNow;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.readyOut <= 1'b0;
        end else begin
            link.readyOut <= mainPowerOkIn && servoOk; // [R2]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.movementFinishOut <= 1'b0;
        end else if (!servoOk) begin // [R10]
            link.movementFinishOut <= 1'b0;
        end else if (holdDone) begin // [R8]
            link.movementFinishOut <= 1'b1;
        end else begin
            link.movementFinishOut <= idleNow && inRange; // [R10] [R11]
        end
    end

    // range 0 means rough match only once the command is fully out
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.roughMatchOut <= 1'b0;
        end else if (!servoOk) begin // [R12]
            link.roughMatchOut <= 1'b0;
        end else if (holdDone) begin // [R8]
            link.roughMatchOut <= 1'b1;
        end else begin
            link.roughMatchOut <= idleNow && (cmdRemainIn <= roughMatchRangeParam); // [R12]
        end
    end

    // in-position follows feedback droop, also while a move runs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.inPositionOut <= 1'b0;
        end else if (!servoOk) begin // [R13]
            link.inPositionOut <= 1'b0;
        end else if (holdDone) begin // [R8]
            link.inPositionOut <= 1'b1;
        end else begin
            link.inPositionOut <= inRange; // [R13]
        end
    end

    assign fwdLimit = $signed({1'b0, forwardTorqueLimitParam});
    assign revLimit = -$signed({1'b0, reverseTorqueLimitParam});

    // clamp applied every cycle, not only while operating
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            torqueCmd <= '0;
        end else if (torqueReqIn > fwdLimit) begin // [R14]
            torqueCmd <= fwdLimit;
        end else if (torqueReqIn < revLimit) begin // [R14]
            torqueCmd <= revLimit;
        end else begin
            torqueCmd <= torqueReqIn;
        end
    end
endmodule : psc_device
`default_nettype wire

// ===== core/psc_ctrl.sv
// Purpose: controller end issuing start pulses and waiting for completion
// Assumes: same clock as the amplifier end
// Notes: pulse length parameter shortens simulation
`timescale 1ns/10ps
`default_nettype none
module psc_ctrl
    import psc_pkg::*;
#(
    parameter int PULSE_CYC = START_PULSE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link to amplifier
    psc_link_if.ctrl link,
    // user side
    input wire logic moveReq,
    input wire logic moveReverse,
    input wire logic tableConfirmed,
    input wire logic servoOnReq,
    input wire logic forcedStopReq,
    input wire logic pauseReq,
    output logic busy,
    output logic done
);
    psc_host_state_t state_r;
    logic [31:0] cnt_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.servoOnIn <= 1'b0;
            link.forcedStopIn <= 1'b0;
            link.temporaryStopRestartIn <= 1'b0;
        end else begin
            link.servoOnIn <= servoOnReq;
            link.forcedStopIn <= forcedStopReq;
            link.temporaryStopRestartIn <= pauseReq;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= PSC_H_IDLE;
            cnt_r <= '0;
            link.forwardStartIn <= 1'b0;
            link.reverseStartIn <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                PSC_H_IDLE: begin
                    // gated by ready and confirmed point table
                    if (moveReq && link.readyOut && tableConfirmed) begin // [R2] [R9]
                        link.forwardStartIn <= !moveReverse;
                        link.reverseStartIn <= moveReverse;
                        cnt_r <= '0;
                        busy <= 1'b1;
                        state_r <= PSC_H_PULSE;
                    end
                end
                PSC_H_PULSE: begin
                    if (cnt_r >= 32'(PULSE_CYC - 1)) begin // [R5]
                        link.forwardStartIn <= 1'b0;
                        link.reverseStartIn <= 1'b0;
                        state_r <= PSC_H_DONE;
                    end else begin
                        cnt_r <= cnt_r + 32'h0000_0001;
                    end
                end
                PSC_H_DONE: begin
                    // wait for finish before next start
                    if (link.movementFinishOut) begin // [R7]
                        busy <= 1'b0;
                        done <= 1'b1;
                        state_r <= PSC_H_IDLE;
                    end
                end
                default: state_r <= PSC_H_IDLE;
            endcase
        end
    end
endmodule : psc_ctrl
`default_nettype wire

// ===== bench/psc_link_props.sv
// Purpose: link checks between controller and amplifier ends
// Assumes: one clock, rst_n synchronous
// Notes: start answered two cycles after the edge sample
`timescale 1ns/10ps
`default_nettype none
module psc_link_props
    import psc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    input wire logic forwardStartIn,
    input wire logic reverseStartIn,
    input wire logic servoOnIn,
    input wire logic movementFinishOut,
    input wire logic roughMatchOut,
    input wire logic inPositionOut,
    // amplifier side
    input wire logic mainPowerOkIn,
    input wire logic startPulse,
    input wire logic operating,
    input wire logic signed [TRQ_W:0] torqueCmd,
    input wire logic [TRQ_W-1:0] forwardTorqueLimitParam,
    input wire logic [TRQ_W-1:0] reverseTorqueLimitParam
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic anyStart;
    assign anyStart = forwardStartIn || reverseStartIn;
    AST_START_EDGE: assert property (startPulse |-> $past(anyStart, 3) && !$past(anyStart, 4))
        else $error("start pulse without a fresh edge");
    AST_PULSE_ONE: assert property (startPulse |=> !startPulse)
        else $error("start pulse longer than one cycle");
    AST_NO_POWER: assert property (startPulse |-> $past(mainPowerOkIn, 3))
        else $error("start taken without main power");
    AST_NO_RESTART: assert property (startPulse |-> !$past(operating, 2))
        else $error("start taken while operating");
    AST_HOLD: assert property ($rose(anyStart) |-> anyStart [*8])
        else $error("start input pulse too short");
    AST_MOVEMENT_FINISH_OUT_RUN: assert property (operating |-> !movementFinishOut)
        else $error("finish high while operating");
    AST_MOVEMENT_FINISH_OUT_SON: assert property (movementFinishOut |-> $past(servoOnIn))
        else $error("finish high with servo off");
    AST_CPO: assert property (roughMatchOut |-> $past(servoOnIn) && !operating)
        else $error("rough match out of place");
    AST_INP: assert property (inPositionOut |-> $past(servoOnIn))
        else $error("in position with servo off");
    AST_TRQ: assert property (operating |-> torqueCmd <= $signed({1'b0, forwardTorqueLimitParam})
        && torqueCmd >= -$signed({1'b0, reverseTorqueLimitParam}))
        else $error("torque outside limits");
    COV_START: cover property (startPulse);
    COV_REV: cover property ($rose(reverseStartIn));
    COV_ALL: cover property (movementFinishOut && roughMatchOut && inPositionOut);
endmodule : psc_link_props
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: both ends joined, moves from a table, then stop and power cases
// Assumes: controller pulse shortened to 8 cycles
// Notes: power-loss case last, movement finish stays high so the controller still completes
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import psc_pkg::*;
    typedef struct packed {logic rev; logic signed [TRQ_W:0] req; logic signed [TRQ_W:0] exp;} psc_row_t;
    logic clk = 0, rst_n = 0, powerOk = 1, cmdDone = 0, moveReq = 0, moveRev = 0, stopReq = 0;
    logic alarm = 0, servoOn = 1;
    logic [TRQ_W-1:0] fwdLim = TRQ_LIMIT_RST;
    logic [POS_W-1:0] droop = 24'h00_0000;
    logic startPulse, startReverse, operating, busy, done;
    logic signed [TRQ_W:0] torqueReq = 0, torqueCmd;
    logic [TRQ_W-1:0] revLim = 16'h01F4;
    int fail_count = 0, check_count = 0, n;
    psc_row_t rows [4] = '{'{1'b0, 17'h0_00C8, 17'h0_00C8}, '{1'b1, 17'h0_05DC, 17'h0_03E8},
        '{1'b1, 17'h1_FED4, 17'h1_FED4}, '{1'b0, 17'h1_FC7C, 17'h1_FE0C}};
    always #2 clk = ~clk;
    psc_link_if link ();
    psc_device u_psc_device (.clk(clk), .rst_n(rst_n), .link(link), .mainPowerOkIn(powerOk), .alarmIn(alarm),
        .inPositionRangeParam(IN_POS_RANGE_RST), .roughMatchRangeParam(ROUGH_RANGE_RST),
        .forwardTorqueLimitParam(fwdLim), .reverseTorqueLimitParam(revLim), .cmdDoneIn(cmdDone),
        .cmdRemainIn(24'h00_0000), .droopIn(droop), .torqueReqIn(torqueReq), .startPulse(startPulse),
        .startReverse(startReverse), .operating(operating), .torqueCmd(torqueCmd));
    psc_ctrl #(.PULSE_CYC(8)) u_psc_ctrl (.clk(clk), .rst_n(rst_n), .link(link), .moveReq(moveReq),
        .moveReverse(moveRev), .tableConfirmed(1'b1), .servoOnReq(servoOn), .forcedStopReq(stopReq),
        .pauseReq(1'b0), .busy(busy), .done(done));
    psc_link_props u_props (.clk(clk), .rst_n(rst_n), .forwardStartIn(link.forwardStartIn),
        .reverseStartIn(link.reverseStartIn), .servoOnIn(link.servoOnIn),
        .movementFinishOut(link.movementFinishOut), .roughMatchOut(link.roughMatchOut),
        .inPositionOut(link.inPositionOut), .mainPowerOkIn(powerOk), .startPulse(startPulse),
        .operating(operating), .torqueCmd(torqueCmd), .forwardTorqueLimitParam(fwdLim),
        .reverseTorqueLimitParam(revLim));
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic run_move(input logic rev, input logic signed [TRQ_W:0] req);
        moveRev = rev;
        torqueReq = req;
        cmdDone = 0;
        moveReq = 1;
        step(1);
        moveReq = 0;
        for (n = 0; n < 50 && startPulse !== 1'b1; n++) step(1);
        check(startPulse === 1'b1, "no start pulse");
    endtask : run_move
    task automatic finish_move();
        cmdDone = 1;
        for (n = 0; n < 50 && done !== 1'b1; n++) step(1);
        check(done === 1'b1, "no done");
    endtask : finish_move
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end
    initial begin
        step(10);
        check(startPulse === 0 && done === 0 && link.movementFinishOut === 0, "reset state");
        rst_n = 1;
        step(10);
        foreach (rows[i]) begin
            run_move(rows[i].rev, rows[i].req);
            step(3);
            check(startReverse === rows[i].rev, "direction");
            check(torqueCmd === rows[i].exp, "torque clamp");
            check(link.movementFinishOut === 0, "finish while running");
            check(operating === 1'b1 && busy === 1'b1, "not running");
            finish_move();
            check(link.movementFinishOut === 1, "finish missing");
            step(12);
        end
        // feedback droop just past and at the in-position range
        droop = IN_POS_RANGE_RST + 24'h00_0001;
        step(2);
        check(link.inPositionOut === 0 && link.movementFinishOut === 0, "in position outside range");
        droop = IN_POS_RANGE_RST;
        step(2);
        check(link.inPositionOut === 1 && link.movementFinishOut === 1, "in position at range edge");
        droop = 24'h00_0000;
        // stop mid-move, then forced stop released
        run_move(1'b0, 17'h0_0000);
        step(3);
        stopReq = 1;
        step(4);
        stopReq = 0;
        for (n = 0; n < 20 && !(link.movementFinishOut && link.roughMatchOut && link.inPositionOut); n++) step(1);
        check(link.movementFinishOut && link.roughMatchOut && link.inPositionOut, "completion after stop");
        cmdDone = 1;
        step(20);
        // alarm and servo-off abort, then servo back on
        run_move(1'b1, 17'h0_0000);
        alarm = 1;
        servoOn = 0;
        step(3);
        check(!link.movementFinishOut && !link.roughMatchOut && !link.inPositionOut, "outputs with servo off");
        check(link.readyOut === 1'b0, "ready with servo off");
        alarm = 0;
        servoOn = 1;
        for (n = 0; n < 20 && !(link.movementFinishOut && link.roughMatchOut && link.inPositionOut); n++) step(1);
        check(link.movementFinishOut && link.roughMatchOut && link.inPositionOut, "completion after alarm");
        step(20);
        // power lost as the start goes out: ready still high, so the start reaches the amplifier
        moveRev = 0;
        powerOk = 0;
        moveReq = 1;
        step(1);
        moveReq = 0;
        check(link.forwardStartIn === 1'b1, "start not driven");
        for (n = 0; n < 20 && startPulse !== 1'b1; n++) step(1);
        check(startPulse === 1'b0, "start without power");
        check(link.readyOut === 1'b0, "ready without power");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
